// *** dtg_top.sv ***
// Purpose: dual-tone dialer generator with power-down and tone enable
// Assumes: i_clk at 25 MHz stands in for the tone clock
// Notes: o_tone_code feeds a converter; 8'h80 is mid-supply
// Notes on behaviour
// R1: power-down forces output to logic zero
// R2: both registers writable during power-down
// R3: software times each tone's duration
// R4: new selection switches both tones at once
// R5: disabled or empty selection rests at mid
// R6: valid selection gives dual or single tone
// R7: one-hot rows and columns pick frequencies
// R8: row and column frequencies near nominal
// R9: software writes only valid one-hot patterns
// R10: one control and one select register
// R11: tone logic runs from the tone clock
// R12: software starts full-speed mode before tones
// R13: phase accumulators feed summed sine samples
`timescale 1ns/100ps
`default_nettype none
`include "dtg_defines.svh"

module dtg_top (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ctrl_wr,
	input wire dtg_pkg::dtg_ctrl_t i_ctrl_wdata,
	output dtg_pkg::dtg_ctrl_t o_ctrl_rdata,
	input wire logic i_sel_wr,
	input wire dtg_pkg::dtg_sel_t i_sel_wdata,
	output dtg_pkg::dtg_sel_t o_sel_rdata,
	output dtg_pkg::dtg_code_t o_tone_code,
	output logic o_tone_active
);
	import dtg_pkg::*;

	dtg_ctrl_t tone_control_reg;
	dtg_sel_t tone_select_reg;
	dtg_mode_t mode;
	logic tone_power_down;
	logic tone_enable;
	logic [3:0] row_freq_select;
	logic [3:0] column_freq_select;
	logic [8:0] sum_wide;
	logic sel_wr_q;

	dtg_tone_if row_if ();
	dtg_tone_if col_if ();

	// one-hot select to phase step; other patterns silence the component
	function automatic dtg_inc_t row_step(input logic [3:0] s);
		case (s)
			4'h1: row_step = dtg_inc_t'(`DTG_INC(`DTG_HZ_R1));
			4'h2: row_step = dtg_inc_t'(`DTG_INC(`DTG_HZ_R2));
			4'h4: row_step = dtg_inc_t'(`DTG_INC(`DTG_HZ_R3));
			4'h8: row_step = dtg_inc_t'(`DTG_INC(`DTG_HZ_R4));
			default: row_step = '0;
		endcase
	endfunction : row_step

	function automatic dtg_inc_t col_step(input logic [3:0] s);
		case (s)
			4'h1: col_step = dtg_inc_t'(`DTG_INC(`DTG_HZ_C1));
			4'h2: col_step = dtg_inc_t'(`DTG_INC(`DTG_HZ_C2));
			4'h4: col_step = dtg_inc_t'(`DTG_INC(`DTG_HZ_C3));
			4'h8: col_step = dtg_inc_t'(`DTG_INC(`DTG_HZ_C4));
			default: col_step = '0;
		endcase
	endfunction : col_step

	// control register, written whatever the power-down state
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			tone_control_reg <= `DTG_CTRL_RST;
		end else if (i_ctrl_wr) begin
			tone_control_reg <= i_ctrl_wdata; // R2 R10
		end
	end

	// select register, likewise always writable
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			tone_select_reg <= `DTG_SEL_RST;
		end else if (i_sel_wr) begin
			tone_select_reg <= i_sel_wdata; // R2 R10
		end
	end

	// restart both phases in the cycle the new selection takes effect
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sel_wr_q <= 1'b0;
		end else begin
			sel_wr_q <= i_sel_wr; // R4
		end
	end

	assign o_ctrl_rdata = tone_control_reg;
	assign o_sel_rdata = tone_select_reg;
	assign tone_power_down = tone_control_reg[`DTG_CTRL_PD_BIT];
	assign tone_enable = tone_control_reg[`DTG_CTRL_EN_BIT];
	assign row_freq_select = tone_select_reg[`DTG_ROW_LSB +: 4];
	assign column_freq_select = tone_select_reg[`DTG_COL_LSB +: 4];

	always_comb begin
		if (tone_power_down) begin
			mode = DTG_OFF; // R1
		end else if (!tone_enable || tone_select_reg == '0) begin
			mode = DTG_IDLE; // R5
		end else begin
			mode = DTG_TONE; // R6
		end
	end

	// both components take their new step in the same cycle
	assign row_if.inc = row_step(row_freq_select); // R7 R8 R4
	assign col_if.inc = col_step(column_freq_select); // R7 R8 R4
	assign row_if.run = (mode == DTG_TONE) && (row_if.inc != '0); // R7
	assign col_if.run = (mode == DTG_TONE) && (col_if.inc != '0); // R7
	assign row_if.restart = sel_wr_q;
	assign col_if.restart = sel_wr_q;

	dtg_osc u_row_osc (
		.i_clk(i_clk), // R11
		.i_srst(i_srst),
		.tone(row_if.osc)
	);

	dtg_osc u_col_osc (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.tone(col_if.osc)
	);

	assign sum_wide = 9'(`DTG_MID_CODE) + 9'($signed(row_if.sample) + $signed(col_if.sample));

	// output converter code, biased at mid-supply
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_tone_code <= `DTG_PD_CODE;
		end else begin
			unique case (mode)
				DTG_OFF: o_tone_code <= `DTG_PD_CODE; // R1
				DTG_IDLE: o_tone_code <= `DTG_MID_CODE; // R5
				DTG_TONE: o_tone_code <= sum_wide[7:0]; // R6 R13
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_tone_active <= 1'b0;
		end else begin
			o_tone_active <= (mode == DTG_TONE);
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	a_pd_forces_zero: assert property ( // R1
		tone_power_down |=> o_tone_code == `DTG_PD_CODE && !o_tone_active
	) else $error("power-down did not force output low");

	a_ctrl_write_pd: assert property ( // R2
		tone_power_down && i_ctrl_wr |=> o_ctrl_rdata == $past(i_ctrl_wdata)
	) else $error("control write lost in power-down");

	a_sel_write_pd: assert property ( // R2
		tone_power_down && i_sel_wr |=> o_sel_rdata == $past(i_sel_wdata)
	) else $error("select write lost in power-down");

	a_sel_both_switch: assert property ( // R4
		i_sel_wr |=> row_if.inc == row_step($past(i_sel_wdata[3:0]))
			&& col_if.inc == col_step($past(i_sel_wdata[7:4]))
			&& row_if.restart && col_if.restart
	) else $error("tone pair did not switch together");

	a_disabled_mid: assert property ( // R5
		!tone_power_down && !tone_enable |=> o_tone_code == `DTG_MID_CODE
	) else $error("disabled tone not at mid bias");

	a_empty_sel_mid: assert property ( // R5
		!tone_power_down && tone_enable && tone_select_reg == '0
			|=> o_tone_code == `DTG_MID_CODE
	) else $error("empty selection not at mid bias");

	a_tone_sum_code: assert property ( // R6
		mode == DTG_TONE |=> o_tone_code == $past(sum_wide[7:0]) && o_tone_active
	) else $error("tone code not the biased sum");

	a_row_step_map: assert property ( // R8
		row_freq_select == 4'h8 |-> row_if.inc == dtg_inc_t'(`DTG_INC(`DTG_HZ_R4))
	) else $error("top row step wrong");

	a_single_row_only: assert property ( // R7
		mode == DTG_TONE && column_freq_select == '0 ##2 mode == DTG_TONE
			&& column_freq_select == '0 |-> !col_if.run && col_if.sample == '0
	) else $error("single row tone carries a column");

	a_pd_osc_silent: assert property ( // R1
		tone_power_down |=> row_if.sample == '0 && col_if.sample == '0
	) else $error("oscillators still running in power-down");

	a_idle_osc_stopped: assert property ( // R5
		mode == DTG_IDLE |-> !row_if.run && !col_if.run
	) else $error("oscillator running while idle");

	a_reselect_phase_zero: assert property ( // R4
		i_sel_wr |=> ##2 row_if.sample == '0 && col_if.sample == '0
	) else $error("phases did not restart together");

	a_active_never_zero: assert property ( // R6
		o_tone_active |-> o_tone_code != `DTG_PD_CODE
	) else $error("sounding tone at logic zero");

	c_dual_tone: cover property (
		mode == DTG_TONE && row_if.run && col_if.run ##8 o_tone_active
	);
	c_single_tone: cover property (mode == DTG_TONE && !col_if.run && row_if.run);
	c_pd_write: cover property (tone_power_down && i_sel_wr);
	c_reselect: cover property (o_tone_active && i_sel_wr);
	c_single_column: cover property (mode == DTG_TONE && col_if.run && !row_if.run);
endmodule : dtg_top

`default_nettype wire

// *** dtg_defines.svh ***
// Purpose: constants of the dual-tone dialer generator
// Assumes: system clock of 25 MHz drives the phase accumulators
// Notes: increments are derived from the clock rate, never typed in
`ifndef DTG_DEFINES_SVH
`define DTG_DEFINES_SVH

// control word layout and reset
`define DTG_CTRL_PD_BIT 0
`define DTG_CTRL_EN_BIT 1
`define DTG_CTRL_RST 2'h1
// select word layout and reset
`define DTG_ROW_LSB 0
`define DTG_COL_LSB 4
`define DTG_SEL_RST 8'h00
// output converter codes
`define DTG_PD_CODE 8'h00
`define DTG_MID_CODE 8'h80
// clock rate in hertz and phase accumulator width
`define DTG_CLK_HZ 25000000
`define DTG_PHASE_W 24
// generated frequencies in hertz
`define DTG_HZ_R1 699
`define DTG_HZ_R2 766
`define DTG_HZ_R3 847
`define DTG_HZ_R4 948
`define DTG_HZ_C1 1215
`define DTG_HZ_C2 1332
`define DTG_HZ_C3 1472
`define DTG_HZ_C4 1633
// phase step per clock for a frequency, rounded to nearest
`define DTG_INC(hz) ((((64'h1 << `DTG_PHASE_W) * (hz)) + (`DTG_CLK_HZ / 2)) / `DTG_CLK_HZ)

`endif

// *** dtg_pkg.sv ***
// Purpose: types of the dual-tone dialer generator
// Assumes: dtg_defines.svh gives the widths
// Notes: none
`include "dtg_defines.svh"

package dtg_pkg;
	typedef logic [1:0] dtg_ctrl_t;
	typedef logic [7:0] dtg_sel_t;
	typedef logic [7:0] dtg_code_t;
	typedef logic [`DTG_PHASE_W-1:0] dtg_inc_t;
	typedef logic signed [7:0] dtg_sample_t;
	typedef enum logic [2:0] {
		DTG_OFF = 3'h1,
		DTG_IDLE = 3'h2,
		DTG_TONE = 3'h4
	} dtg_mode_t;
endpackage : dtg_pkg

// *** dtg_tone_if.sv ***
// Purpose: link between the tone selector and one oscillator
// Assumes: one clock for both ends
// Notes: restart is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none

interface dtg_tone_if;
	import dtg_pkg::*;
	dtg_inc_t inc;
	logic run;
	logic restart;
	dtg_sample_t sample;
	modport ctl (output inc, output run, output restart, input sample);
	modport osc (input inc, input run, input restart, output sample);
endinterface : dtg_tone_if

`default_nettype wire

// *** dtg_osc.sv ***
// Purpose: one sine oscillator, phase accumulator plus quarter-wave table
// Assumes: inc is the phase step per clock
// Notes: 32 table steps per period, one sample per clock, amplitude 63
`timescale 1ns/100ps
`default_nettype none
`include "dtg_defines.svh"

module dtg_osc #(
	parameter int PHASE_W = `DTG_PHASE_W
) (
	input wire logic i_clk,
	input wire logic i_srst,
	dtg_tone_if.osc tone
);
	import dtg_pkg::*;

	logic [PHASE_W-1:0] phase;
	logic [3:0] qidx;
	logic [4:0] top;

	if (PHASE_W < 8 || PHASE_W != $bits(dtg_inc_t)) begin : g_bad_phase_w
		$error("dtg_osc: phase width not served");
	end

	function automatic logic [5:0] quarter(input logic [3:0] k);
		case (k)
			4'h0: quarter = 6'h00;
			4'h1: quarter = 6'h0C;
			4'h2: quarter = 6'h18;
			4'h3: quarter = 6'h23;
			4'h4: quarter = 6'h2D;
			4'h5: quarter = 6'h34;
			4'h6: quarter = 6'h3A;
			4'h7: quarter = 6'h3E;
			default: quarter = 6'h3F;
		endcase
	endfunction : quarter

	// phase restarts together with the other oscillator on a new selection
	always_ff @(posedge i_clk) begin
		if (i_srst || tone.restart || !tone.run) begin
			phase <= '0;
		end else begin
			phase <= phase + tone.inc; // R13
		end
	end

	assign top = phase[PHASE_W-1 -: 5];
	assign qidx = top[3] ? 4'(4'h8 - {1'b0, top[2:0]}) : {1'b0, top[2:0]};

	always_ff @(posedge i_clk) begin
		if (i_srst || !tone.run) begin
			tone.sample <= '0;
		end else if (top[4]) begin
			tone.sample <= -$signed({2'b00, quarter(qidx)}); // R13
		end else begin
			tone.sample <= $signed({2'b00, quarter(qidx)});
		end
	end
endmodule : dtg_osc

`default_nettype wire

// *** dtg_line_model.sv ***
// Purpose: line-side receiver that times tone half periods
// Assumes: code 8'h80 is mid-supply
// Notes: reports the rise-to-fall span around mid-supply
`timescale 1ns/100ps
`default_nettype none

module dtg_line_model (
	input wire logic i_clk,
	input wire dtg_pkg::dtg_code_t i_code,
	output int o_half,
	output logic o_done
);
	import dtg_pkg::*;
	dtg_code_t prev = 8'h80;
	int cnt = 0;
	always @(posedge i_clk) begin
		o_done <= 1'b0;
		cnt <= cnt + 1;
		if (prev <= 8'h80 && i_code > 8'h80) begin
			cnt <= 1;
		end
		// logic zero of power-down is not a tone swing
		if (prev >= 8'h80 && i_code < 8'h80 && i_code != 8'h00) begin
			o_half <= cnt;
			o_done <= 1'b1;
		end
		prev <= i_code;
	end
endmodule : dtg_line_model

`default_nettype wire

// *** dtg_top_tb_top.sv ***
// Purpose: self-checking bench of the dual-tone dialer generator
// Assumes: 25 MHz clock, writes one cycle long
// Notes: none
`timescale 1ns/100ps
`default_nettype none

module dtg_top_tb_top;
	import dtg_pkg::*;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic cw = 1'b0;
	logic sw = 1'b0;
	dtg_ctrl_t cd = 2'h0;
	dtg_sel_t sd = 8'h00;
	dtg_ctrl_t crd;
	dtg_sel_t srd;
	dtg_code_t code;
	logic act;
	int half;
	logic done;
	int fails = 0;
	int samples_checked = 0;
	int n;
	dtg_sel_t v;
	dtg_top DUT (.i_clk(i_clk), .i_srst(i_srst), .i_ctrl_wr(cw), .i_ctrl_wdata(cd),
		.o_ctrl_rdata(crd), .i_sel_wr(sw), .i_sel_wdata(sd), .o_sel_rdata(srd),
		.o_tone_code(code), .o_tone_active(act));
	dtg_line_model line (.i_clk(i_clk), .i_code(code), .o_half(half), .o_done(done));
	initial begin
		forever #20 i_clk = ~i_clk;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask : tick
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic near(input int got, input int exp);
		samples_checked++;
		if (got * 200 > exp * 201 || got * 200 < exp * 199) begin
			fails++;
			$display("CHECK FAILED %0t half period %0d exp %0d", $time, got, exp);
		end
	endtask : near
	// returns one edge after the write edge: readback and new output both settled
	task automatic put(input logic c, input logic [7:0] d);
		cw = c;
		sw = !c;
		cd = d[1:0];
		sd = d;
		tick(1);
		cw = 1'b0;
		sw = 1'b0;
		tick(1);
	endtask : put
	task automatic wait_half;
		n = 0;
		while (done !== 1'b1 && n < 40000) begin
			tick(1);
			n++;
		end
		if (n >= 40000) begin
			fails++;
			$display("CHECK FAILED %0t no tone swing seen", $time);
		end
	endtask : wait_half
	task automatic conclude;
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	initial begin
		#3000000;
		fails++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		conclude();
	end
	initial begin
		tick(2);
		i_srst = 1'b0;
		chk({6'h00, crd}, 8'h01);
		chk(srd, 8'h00);
		chk(code, 8'h00);
		chk({7'h00, act}, 8'h00);
		put(1, 8'h03);
		put(0, 8'h11);
		chk({6'h00, crd}, 8'h03);
		chk(srd, 8'h11);
		repeat (8) begin
			chk(code, 8'h00);
			tick(5);
		end
		put(0, 8'h00);
		put(1, 8'h00);
		chk(code, 8'h80);
		put(1, 8'h02);
		repeat (8) begin
			chk(code, 8'h80);
			chk({7'h00, act}, 8'h00);
			tick(5);
		end
		for (int r = 0; r < 5; r++) begin
			for (int c = 0; c < 5; c++) begin
				if (r != 0 || c != 0) begin
					v = (r != 0 ? 8'h01 << (r - 1) : 8'h00) | (c != 0 ? 8'h10 << (c - 1) : 8'h00);
					put(0, v);
					chk(srd, v);
					chk({7'h00, act}, 8'h01);
					// samples of the old pair drain for two cycles, then both restart at zero
					tick(2);
					chk(code, 8'h80);
					n = 0;
					while (code === 8'h80 && n < 1200) begin
						tick(1);
						n++;
					end
					chk({7'h00, code != 8'h80}, 8'h01);
				end
			end
		end
		put(0, 8'h01);
		wait_half();
		near(half, 25000000 / (2 * 699));
		put(0, 8'h80);
		wait_half();
		near(half, 25000000 / (2 * 1633));
		put(1, 8'h03);
		chk(code, 8'h00);
		chk({7'h00, act}, 8'h00);
		conclude();
	end
endmodule : dtg_top_tb_top

`default_nettype wire
